//--- logic/ods_map.svh
`ifndef ODS_MAP_SVH
`define ODS_MAP_SVH
// Contract
// (RQ1) Entry repetition count: 0 means no loop, 2..255 passes; resets to 0.
// (RQ2) Span from loop-count entry through range-end entry repeats exactly count passes.
// (RQ3) After the final pass, continue at the range-end entry's follow-on selection.
// (RQ4) Range-end flag: 0 ordinary, 1 last entry of span; resets to 0.
// (RQ5) Selector: -256 stop, -2 skip two, -1 next, 0..255 direct; resets -1.
// (RQ6) Link mode: 0 none, 1 manual, 2 automatic, 3 continuous; resets to 0.
// (RQ7) Link mode 0 inside a span halts after that entry, abandoning remaining passes.
// (RQ8) Signed per-entry offset, -4194304..4194303 steps, reset zero, accumulated per pass.
// (RQ9) Absolute entries shift the target coordinate by the accumulated offset.
// (RQ10) Incremental entries shift the travel distance by the accumulated offset.
// (RQ11) Endless repetition through selectors alone applies no per-pass offset.
// (RQ12) Automatic: after completion wait the entry's delay, then start follow-on unprompted.
// (RQ13) Continuous: at target pass to follow-on without stopping, ramping from present speed.
// (RQ14) Manual: host raises sequential start while ready; device starts, drops ready.
// (RQ15) When all linked entries complete, busy falls and ready rises.
// (RQ16) Pass counter and accumulated offset clear when span finishes or sequence stops.

// =====================================================================
// Bus map: address = {status select, entry index, field index}.
`define ODS_FLD_CTRL 2'h0
`define ODS_FLD_POS 2'h1
`define ODS_FLD_OFFS 2'h2
`define ODS_FLD_DLY 2'h3
`define ODS_STATUS_BIT 10

// =====================================================================
// Control word field positions.
`define ODS_CTRL_LINK_LO 0
`define ODS_CTRL_LINK_HI 1
`define ODS_CTRL_NEXT_LO 2
`define ODS_CTRL_NEXT_HI 10
`define ODS_CTRL_LOOP_LO 11
`define ODS_CTRL_LOOP_HI 18
`define ODS_CTRL_END 19
`define ODS_CTRL_INCR 20

// =====================================================================
// Selector codes and reset values.
`define ODS_NEXT_STOP 9'h100
`define ODS_NEXT_SKIP (-9'sd2)
`define ODS_NEXT_PLUS1 (-9'sd1)
`define ODS_RST_NEXT 9'h1ff
`define ODS_RST_LOOP 8'h00
`define ODS_RST_END 1'b0
`define ODS_RST_OFFS 23'h000000

// =====================================================================
// Timing: delay unit 1 ms at a 20 ns clock.
`define ODS_CLK_NS 20
`define ODS_DLY_UNIT_NS 1000000
`define ODS_DLY_UNIT_CYC ((`ODS_DLY_UNIT_NS + `ODS_CLK_NS - 1) / `ODS_CLK_NS)
`endif

//--- logic/ods_pkg.sv
package ods_pkg;
    // Link modes in their stored order: none, manual, automatic, continuous.
    typedef enum logic [1:0] {LNK_NONE, LNK_MANUAL, LNK_AUTO, LNK_CONT} ods_link_t;
    // Sequencer states.
    typedef enum logic [2:0] {ST_IDLE, ST_ISSUE, ST_RUN, ST_DELAY, ST_MANUAL} ods_state_t;
    // One stored positioning entry.
    typedef struct packed {
        ods_link_t link;
        logic signed [8:0] next;
        logic [7:0] loop_cnt;
        logic range_end;
        logic incr;
        logic signed [31:0] pos;
        logic signed [22:0] offs;
        logic [15:0] dly;
    } ods_entry_t;
    // Command handed to the motion generator.
    typedef struct packed {
        logic signed [31:0] target;
        logic incr;
        logic blend;
        logic [7:0] entry;
    } ods_cmd_t;
endpackage : ods_pkg

//--- logic/ods_seq.sv
// Design decisions made here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/100ps
`include "ods_map.svh"
module ods_seq
    import ods_pkg::*;
#(
    parameter int N_ENTRY = 256,
    parameter int P_UNIT_CYCLES = `ODS_DLY_UNIT_CYC
)(
    // Clock and reset.
    input wire logic i_mclk,
    input wire logic i_rstn,
    // Register port.
    input wire logic [10:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    // Host pins.
    input wire logic i_start,
    input wire logic [7:0] i_sel,
    input wire logic i_sequential_start,
    input wire logic i_stop,
    output logic o_ready,
    output logic o_sequence_busy,
    // Motion generator.
    output logic o_cmd_valid,
    output ods_cmd_t o_cmd,
    input wire logic i_mg_done
);

    // =====================================================================
    // Elaboration checks.
    if (N_ENTRY != 256) $error("ods_seq: N_ENTRY must be 256 to match 8-bit selectors");
    if (P_UNIT_CYCLES < 1) $error("ods_seq: P_UNIT_CYCLES must be at least 1");

    // =====================================================================
    // Declarations.
    ods_entry_t tbl [N_ENTRY];
    ods_state_t state;
    logic [7:0] cur;
    logic loop_on;
    logic [7:0] loop_start;
    logic [7:0] loop_left;
    logic [7:0] loop_pass;
    logic [15:0] dly_left;
    logic [31:0] presc;
    logic blend;
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic [7:0] sel1;
    logic [7:0] sel2;
    logic start_d;
    logic sequential_start_input_d;

    // =====================================================================
    // Host pins pass two flops before any logic reads them.
    always_ff @(posedge i_mclk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            sync1 <= 3'h0;
            sync2 <= 3'h0;
            sel1 <= 8'h00;
            sel2 <= 8'h00;
            start_d <= 1'b0;
            sequential_start_input_d <= 1'b0;
        end
        else
        begin
            sync1 <= {i_stop, i_sequential_start, i_start};
            sync2 <= sync1;
            sel1 <= i_sel;
            sel2 <= sel1;
            start_d <= sync2[0];
            sequential_start_input_d <= sync2[1];
        end
    end

    wire stop_s = sync2[2];
    wire start_rise = sync2[0] && !start_d;
    wire sequential_start_input_rise = sync2[1] && !sequential_start_input_d; // RQ14

    // =====================================================================
    // Follow-on decode for the entry in progress.
    wire ods_entry_t e = tbl[cur];
    wire sel_stop = (e.next < `ODS_NEXT_SKIP); // RQ5
    wire [7:0] sel_idx = (e.next == `ODS_NEXT_SKIP) ? 8'(cur + 8'h02) :
                         (e.next == `ODS_NEXT_PLUS1) ? 8'(cur + 8'h01) : e.next[7:0]; // RQ5
    wire at_end = e.range_end && loop_on; // RQ4
    wire loop_again = at_end && (loop_left > 8'h01); // RQ2
    wire [7:0] next_idx = loop_again ? loop_start : sel_idx; // RQ3
    wire finish_now = (e.link == LNK_NONE) || (!loop_again && sel_stop); // RQ7
    wire done_ok = (state == ST_RUN) && i_mg_done && !o_cmd_valid;
    wire loop_begin = !loop_on && (e.loop_cnt != 8'h00); // RQ1

    // Offset grows by one entry offset per completed pass; zero outside a counted span.
    wire signed [31:0] offs_acc = loop_on ? 32'($signed({1'b0, loop_pass}) * e.offs) : 32'sh0; // RQ8 RQ11
    wire signed [31:0] tgt_calc = 32'(e.pos + offs_acc); // RQ9 RQ10

    // =====================================================================
    // Register port decode.
    wire st_sel = i_addr[`ODS_STATUS_BIT];
    wire [7:0] a_ent = i_addr[9:2];
    wire [1:0] a_fld = i_addr[1:0];
    wire ods_entry_t re = tbl[a_ent];
    wire [31:0] ctrl_rd = {11'h000, re.incr, re.range_end, re.loop_cnt, re.next, re.link};
    wire [31:0] stat_rd = {5'h00, state, loop_pass, loop_left, cur};
    wire [31:0] fld_rd = (a_fld == `ODS_FLD_CTRL) ? ctrl_rd :
                         (a_fld == `ODS_FLD_POS) ? re.pos :
                         (a_fld == `ODS_FLD_OFFS) ? 32'(re.offs) : {16'h0000, re.dly};
    wire [31:0] rd_mux = st_sel ? stat_rd : fld_rd;

    // Read data stands only in the cycle after the read strobe.
    always_ff @(posedge i_mclk or negedge i_rstn)
    begin
        if (!i_rstn)
            o_rdata <= 32'h00000000;
        else
            o_rdata <= i_rd ? rd_mux : 32'h00000000;
    end

    // =====================================================================
    // Entry table. Writes may land while running; the running entry sees them at once.
    always_ff @(posedge i_mclk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            for (int i = 0; i < N_ENTRY; i++)
            begin
                tbl[i].link <= LNK_NONE; // RQ6
                tbl[i].next <= `ODS_RST_NEXT; // RQ5
                tbl[i].loop_cnt <= `ODS_RST_LOOP; // RQ1
                tbl[i].range_end <= `ODS_RST_END; // RQ4
                tbl[i].incr <= 1'b0;
                tbl[i].pos <= 32'sh0;
                tbl[i].offs <= `ODS_RST_OFFS; // RQ8
                tbl[i].dly <= 16'h0000;
            end
        end
        else if (i_wr && !st_sel)
        begin
            unique case (a_fld)
                `ODS_FLD_CTRL:
                begin
                    tbl[a_ent].link <= ods_link_t'(i_wdata[`ODS_CTRL_LINK_HI:`ODS_CTRL_LINK_LO]); // RQ6
                    tbl[a_ent].next <= i_wdata[`ODS_CTRL_NEXT_HI:`ODS_CTRL_NEXT_LO];
                    tbl[a_ent].loop_cnt <= i_wdata[`ODS_CTRL_LOOP_HI:`ODS_CTRL_LOOP_LO];
                    tbl[a_ent].range_end <= i_wdata[`ODS_CTRL_END];
                    tbl[a_ent].incr <= i_wdata[`ODS_CTRL_INCR];
                end
                `ODS_FLD_POS: tbl[a_ent].pos <= i_wdata;
                `ODS_FLD_OFFS: tbl[a_ent].offs <= i_wdata[22:0];
                `ODS_FLD_DLY: tbl[a_ent].dly <= i_wdata[15:0];
            endcase
        end
    end

    // =====================================================================
    // Sequencer. Outside idle, stop wins over every other event so a runaway span can always be halted.
    always_ff @(posedge i_mclk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            state <= ST_IDLE;
            cur <= 8'h00;
            loop_on <= 1'b0;
            loop_start <= 8'h00;
            loop_left <= 8'h00;
            loop_pass <= 8'h00;
            dly_left <= 16'h0000;
            presc <= 32'h0;
            blend <= 1'b0;
            o_cmd_valid <= 1'b0;
            o_cmd <= '0;
        end
        else
        begin
            o_cmd_valid <= 1'b0;
            if (stop_s && state != ST_IDLE)
            begin
                state <= ST_IDLE;
                loop_on <= 1'b0; // RQ16
                loop_pass <= 8'h00;
                loop_left <= 8'h00;
            end
            else
            begin
                unique case (state)
                    ST_IDLE:
                        if (start_rise)
                        begin
                            cur <= sel2;
                            blend <= 1'b0;
                            state <= ST_ISSUE;
                        end
                    ST_ISSUE:
                    begin
                        if (loop_begin)
                        begin
                            loop_on <= 1'b1; // RQ2
                            loop_start <= cur;
                            loop_left <= e.loop_cnt;
                            loop_pass <= 8'h00;
                        end
                        o_cmd.target <= tgt_calc; // RQ9 RQ10
                        o_cmd.incr <= e.incr;
                        o_cmd.blend <= blend; // RQ13
                        o_cmd.entry <= cur;
                        o_cmd_valid <= 1'b1;
                        state <= ST_RUN;
                    end
                    ST_RUN:
                        if (done_ok)
                        begin
                            if (finish_now || (at_end && !loop_again))
                            begin
                                loop_on <= 1'b0; // RQ16
                                loop_pass <= 8'h00;
                                loop_left <= 8'h00;
                            end
                            else if (loop_again)
                            begin
                                loop_left <= 8'(loop_left - 8'h01); // RQ2
                                loop_pass <= 8'(loop_pass + 8'h01); // RQ8
                            end
                            cur <= next_idx; // RQ3
                            blend <= (e.link == LNK_CONT);
                            dly_left <= e.dly;
                            presc <= 32'h0;
                            if (finish_now)
                                state <= ST_IDLE; // RQ7 RQ15
                            else if (e.link == LNK_MANUAL)
                                state <= ST_MANUAL; // RQ14
                            else if (e.link == LNK_AUTO)
                                state <= ST_DELAY; // RQ12
                            else
                                state <= ST_ISSUE; // RQ13
                        end
                    ST_DELAY:
                        if (dly_left == 16'h0000)
                            state <= ST_ISSUE; // RQ12
                        else if (presc == 32'(P_UNIT_CYCLES - 1))
                        begin
                            presc <= 32'h0;
                            dly_left <= 16'(dly_left - 16'h0001);
                        end
                        else
                            presc <= 32'(presc + 32'h1);
                    ST_MANUAL:
                        if (sequential_start_input_rise)
                            state <= ST_ISSUE; // RQ14
                    default:
                        state <= ST_IDLE;
                endcase
            end
        end
    end

    // =====================================================================
    // Status pins: ready while idle or waiting for a manual step.
    assign o_ready = (state == ST_IDLE) || (state == ST_MANUAL); // RQ14 RQ15
    assign o_sequence_busy = (state != ST_IDLE); // RQ15

    // =====================================================================
    // Checks.
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_rstn);

    chk_busy_not_ready: assert property (o_sequence_busy && state != ST_MANUAL |-> !o_ready) // RQ15
        else $error("ready high while sequence runs");
    chk_issue_cmd_pulse: assert property (state == ST_ISSUE && !stop_s |=> o_cmd_valid && state == ST_RUN) // RQ2
        else $error("issue did not emit a command");
    chk_none_halts: assert property (done_ok && !stop_s && e.link == LNK_NONE // RQ7
        |=> state == ST_IDLE && !o_sequence_busy && o_ready)
        else $error("link none did not halt");
    chk_loop_repeat: assert property (done_ok && !stop_s && loop_again && e.link != LNK_NONE // RQ2
        |=> cur == $past(loop_start) && loop_pass == 8'($past(loop_pass) + 8'h01))
        else $error("span did not repeat");
    chk_loop_exit: assert property (done_ok && !stop_s && at_end && !loop_again && !finish_now // RQ3
        |=> !loop_on && cur == $past(sel_idx))
        else $error("span exit went astray");
    chk_plain_target: assert property (state == ST_ISSUE && !loop_on && !stop_s // RQ11
        |=> o_cmd.target == $past(e.pos))
        else $error("offset applied outside a span");
    chk_span_target: assert property (state == ST_ISSUE && loop_on && !stop_s // RQ9
        |=> o_cmd.target == 32'($past(e.pos) + $signed({1'b0, $past(loop_pass)}) * $past(e.offs)))
        else $error("span target offset wrong");
    chk_delay_end: assert property (state == ST_DELAY && dly_left == 16'h0000 && !stop_s |=> state == ST_ISSUE) // RQ12
        else $error("delay did not resume");
    chk_manual_hold: assert property (state == ST_MANUAL && !sequential_start_input_rise && !stop_s |=> state == ST_MANUAL) // RQ14
        else $error("manual step began unprompted");
    chk_cont_blend: assert property (done_ok && !stop_s && !finish_now && e.link == LNK_CONT // RQ13
        |=> state == ST_ISSUE && blend ##1 (o_cmd.blend || !o_cmd_valid))
        else $error("continuous link not blended");
    chk_idle_clean: assert property (state == ST_IDLE |-> !loop_on && loop_pass == 8'h00) // RQ16
        else $error("loop state left over");
    chk_next_plus1: assert property (done_ok && !stop_s && !loop_again && !finish_now // RQ5
        && e.next == `ODS_NEXT_PLUS1 |=> cur == 8'($past(cur) + 8'h01))
        else $error("next entry decode wrong");
    // Selector, span, pacing and status checks; a stop in flight masks each of them except chk_stop_clears, which checks the stop itself.
    chk_next_skip: assert property (done_ok && !stop_s && !loop_again && !finish_now // RQ5
        && e.next == `ODS_NEXT_SKIP |=> cur == 8'($past(cur) + 8'h02))
        else $error("skip two decode wrong");
    chk_next_direct: assert property (done_ok && !stop_s && !loop_again && !finish_now // RQ5
        && e.next >= 9'sd0 |=> cur == $past(e.next[7:0]))
        else $error("direct entry decode wrong");
    chk_next_stop: assert property (done_ok && !stop_s && !loop_again // RQ5
        && e.next == `ODS_NEXT_STOP |=> state == ST_IDLE)
        else $error("stop selector did not end the sequence");
    chk_span_open: assert property (state == ST_ISSUE && loop_begin && !stop_s // RQ1
        |=> loop_on && loop_start == $past(cur) && loop_left == $past(e.loop_cnt))
        else $error("span did not open with its count");
    chk_span_kept: assert property (state == ST_ISSUE && loop_on && !stop_s // RQ2
        |=> loop_start == $past(loop_start) && loop_left == $past(loop_left))
        else $error("open span was restarted");
    chk_stop_clears: assert property (stop_s && state != ST_IDLE // RQ16
        |=> state == ST_IDLE && !loop_on && loop_left == 8'h00)
        else $error("stop left loop state behind");
    chk_auto_delay: assert property (done_ok && !stop_s && !finish_now && e.link == LNK_AUTO // RQ12
        |=> state == ST_DELAY && dly_left == $past(e.dly))
        else $error("automatic link skipped its delay");
    chk_delay_tick: assert property (state == ST_DELAY && dly_left != 16'h0000 && !stop_s // RQ12
        && presc == 32'(P_UNIT_CYCLES - 1) |=> dly_left == 16'($past(dly_left) - 16'h0001))
        else $error("delay unit not counted");
    chk_manual_wait: assert property (done_ok && !stop_s && !finish_now && e.link == LNK_MANUAL // RQ14
        |=> state == ST_MANUAL && o_ready && o_sequence_busy)
        else $error("manual link did not wait");
    chk_manual_go: assert property (state == ST_MANUAL && sequential_start_input_rise && !stop_s // RQ14
        |=> state == ST_ISSUE && !o_ready)
        else $error("manual step did not begin");
    chk_finish_flags: assert property (done_ok && !stop_s && finish_now // RQ15
        |=> !o_sequence_busy && o_ready && !loop_on)
        else $error("finish left the sequence busy");

    cov_loop_repeat: cover property (done_ok && loop_again);
    cov_manual_step: cover property (state == ST_MANUAL ##[1:50] state == ST_ISSUE);
    cov_cont_link: cover property (done_ok && e.link == LNK_CONT && !finish_now);
    cov_delay_wait: cover property (state == ST_DELAY && dly_left != 16'h0000);
    cov_span_exit: cover property (done_ok && at_end && !loop_again);

endmodule : ods_seq

//--- verification/ods_mg_model.sv
`timescale 1ns/100ps
module ods_mg_model
(
    // Clock and reset.
    input wire logic i_mclk,
    input wire logic i_rstn,
    // Command side.
    input wire logic i_cmd_valid,
    input wire logic i_slow,
    // Completion side.
    output logic o_done
);
    int cnt;
    // =========================================
    // Completion timer: done never shares the command cycle, and a slow run holds the
    // sequencer in its run state long enough to expose any early advance.
    always @(posedge i_mclk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            cnt <= 0;
            o_done <= 1'b0;
        end
        else
        begin
            o_done <= (cnt == 1);
            if (i_cmd_valid)
                cnt <= i_slow ? 25 : 3;
            else if (cnt > 0)
                cnt <= cnt - 1;
        end
    end
endmodule : ods_mg_model

//--- verification/tb_top.sv
`timescale 1ns/100ps
module tb_top
    import ods_pkg::*;
();
    typedef struct {int e; int t; int b;} ods_rec_t;
    logic i_mclk = 0, i_rstn = 0, i_wr = 0, i_rd = 0, i_start = 0, i_sequential_start = 0, i_stop = 0;
    logic i_slow = 0, mg_done, o_ready, o_sequence_busy, o_cmd_valid;
    logic [10:0] i_addr = 11'h000;
    logic [31:0] i_wdata = 32'h0, o_rdata, rd_val;
    logic [7:0] i_sel = 8'h00;
    ods_cmd_t o_cmd;
    ods_cmd_t got_q[$];
    int cyc_q[$];
    ods_rec_t exp_q[$];
    int m_link[256], m_next[256], m_loop[256], m_end[256], m_incr[256], m_pos[256], m_offs[256];
    int bad_count = 0, num_checks = 0, cyc = 0;
    // =========================================
    // Clock, timeout and command capture.
    always #10 i_mclk = ~i_mclk;
    always @(posedge i_mclk)
    begin
        cyc <= cyc + 1;
        if (o_cmd_valid === 1'b1)
        begin
            got_q.push_back(o_cmd);
            cyc_q.push_back(cyc);
        end
        if (cyc == 60000)
        begin
            bad_count++;
            give_verdict();
        end
    end
    ods_seq #(.P_UNIT_CYCLES(4)) ods_seq_i (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_start(i_start), .i_sel(i_sel),
        .i_sequential_start(i_sequential_start), .i_stop(i_stop), .o_ready(o_ready),
        .o_sequence_busy(o_sequence_busy), .o_cmd_valid(o_cmd_valid), .o_cmd(o_cmd), .i_mg_done(mg_done));
    ods_mg_model ods_mg_model_i (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_cmd_valid(o_cmd_valid),
        .i_slow(i_slow), .o_done(mg_done));
    // =========================================
    // Comparison, verdict and bus cycles.
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : give_verdict
    task automatic bus_wr(input logic [10:0] a, input logic [31:0] d);
        @(posedge i_mclk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_mclk);
        i_wr <= 1'b0;
    endtask : bus_wr
    task automatic bus_rd(input logic [10:0] a);
        @(posedge i_mclk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        #1 rd_val = o_rdata;
    endtask : bus_rd
    // Writes one entry through the bus and keeps the bench's own copy in step.
    task automatic set_entry(input int e, lk, nx, lp, en, inc, pos, offs, dly);
        m_link[e] = lk;
        m_next[e] = nx;
        m_loop[e] = lp;
        m_end[e] = en;
        m_incr[e] = inc;
        m_pos[e] = pos;
        m_offs[e] = offs;
        bus_wr({1'b0, 8'(e), 2'h0}, {11'h0, 1'(inc), 1'(en), 8'(lp), 9'(nx), 2'(lk)});
        bus_wr({1'b0, 8'(e), 2'h1}, 32'(pos));
        bus_wr({1'b0, 8'(e), 2'h2}, {9'h0, 23'(offs)});
        bus_wr({1'b0, 8'(e), 2'h3}, 32'(dly));
    endtask : set_entry
    // =========================================
    // Reference walk of the table: spans, passes, offsets and selectors.
    task automatic build(input int sel, input int maxn);
        int cur, sp, left, pass, prev;
        bit open;
        cur = sel;
        open = 0;
        pass = 0;
        prev = 0;
        exp_q.delete();
        while (exp_q.size() < maxn)
        begin
            if (!open && m_loop[cur] != 0)
            begin
                open = 1;
                sp = cur;
                left = m_loop[cur];
            end
            exp_q.push_back('{cur, m_pos[cur] + (open ? pass * m_offs[cur] : 0), prev == 3});
            prev = m_link[cur];
            if (m_link[cur] == 0)
                break;
            if (open && m_end[cur] != 0 && left > 1)
            begin
                left--;
                pass++;
                cur = sp;
                continue;
            end
            if (open && m_end[cur] != 0)
            begin
                open = 0;
                pass = 0;
            end
            if (m_next[cur] < -2)
                break;
            cur = (m_next[cur] < 0) ? (cur - m_next[cur]) % 256 : m_next[cur];
        end
    endtask : build
    // Starts at sel, steps manual waits, stops after maxn commands, then compares.
    task automatic run(input int sel, input int maxn);
        int k;
        build(sel, maxn);
        got_q.delete();
        cyc_q.delete();
        i_sel <= 8'(sel);
        @(posedge i_mclk);
        i_start <= 1'b1;
        for (k = 0; k < 50 && o_sequence_busy !== 1'b1; k++)
            @(posedge i_mclk);
        i_start <= 1'b0;
        for (k = 0; k < 3000 && o_sequence_busy === 1'b1; k++)
        begin
            @(posedge i_mclk);
            i_stop <= (got_q.size() >= maxn);
            i_sequential_start <= (o_ready === 1'b1);
        end
        @(posedge i_mclk);
        i_stop <= 1'b0;
        i_sequential_start <= 1'b0;
        check({o_ready, o_sequence_busy}, 2'b10);
        repeat (30) @(posedge i_mclk);
        if (maxn > exp_q.size())
            check(got_q.size(), exp_q.size());
        foreach (exp_q[i])
        begin
            if (i >= got_q.size())
                break;
            check(got_q[i].entry, 8'(exp_q[i].e));
            check(got_q[i].target, 32'(exp_q[i].t));
            check({got_q[i].incr, got_q[i].blend}, {1'(m_incr[exp_q[i].e]), 1'(exp_q[i].b)});
        end
    endtask : run
    // =========================================
    // Main sequence.
    initial
    begin
        int pa;
        void'($urandom(32'h68c1));
        foreach (m_next[i])
            m_next[i] = -1;
        repeat (20) @(posedge i_mclk);
        i_rstn <= 1'b1;
        bus_rd(11'h320);
        check(rd_val, 32'h000007fc);
        bus_rd(11'h322);
        check(rd_val, 32'h0);
        bus_wr(11'h400, 32'hffffffff);
        bus_rd(11'h400);
        check(rd_val[26:24], 3'h0);
        for (int i = 0; i < 4; i++)
        begin
            set_entry(60 + i, i, -1, 0, 0, 0, 0, 0, 0);
            bus_rd({3'h0, 6'(60 + i), 2'h0});
            check(rd_val, 32'h7fc | i);
        end
        set_entry(64, 0, -1, 0, 0, 0, 0, -4194304, 0);
        bus_rd(11'h102);
        check(rd_val, 32'hffc00000);
        set_entry(65, 0, -1, 0, 0, 0, 0, 4194303, 0);
        bus_rd(11'h106);
        check(rd_val, 32'h003fffff);
        pa = $urandom_range(60000) - 30000;
        set_entry(0, 2, -1, 3, 0, 0, pa, 100, 0);
        set_entry(1, 2, -1, 0, 1, 0, $urandom_range(9999), 0, 0);
        set_entry(2, 0, -256, 0, 0, 0, $urandom_range(9999), 0, 0);
        i_slow <= 1'b1;
        run(0, 3);
        i_slow <= 1'b0;
        run(0, 64);
        set_entry(4, 2, -1, 2, 0, 1, 900, 100, 0);
        set_entry(5, 2, -256, 0, 1, 1, -900, -100, 0);
        run(4, 64);
        set_entry(8, 2, -1, 3, 0, 0, pa, 5, 0);
        set_entry(9, 0, -1, 0, 0, 0, 7, 0, 0);
        set_entry(10, 2, -1, 0, 1, 0, 9, 0, 0);
        run(8, 64);
        set_entry(12, 2, -1, 0, 0, 0, 50, 7, 0);
        set_entry(13, 2, 12, 0, 0, 0, 60, 5, 0);
        run(12, 5);
        set_entry(20, 2, -2, 0, 0, 0, 20, 0, 0);
        set_entry(22, 3, 25, 0, 0, 0, 22, 0, 0);
        set_entry(25, 0, -1, 0, 0, 0, pa, 0, 0);
        run(20, 64);
        set_entry(40, 1, -1, 0, 0, 0, 40, 0, 0);
        set_entry(41, 0, -1, 0, 0, 0, 41, 0, 0);
        run(40, 64);
        set_entry(50, 2, -1, 0, 0, 0, 50, 0, 3);
        set_entry(51, 0, -1, 0, 0, 0, 51, 0, 0);
        run(50, 64);
        check(cyc_q.size() == 2 && cyc_q[1] - cyc_q[0] >= 14 && cyc_q[1] - cyc_q[0] <= 24, 1);
        give_verdict();
    end
endmodule : tb_top
